// ==== rtl/nv_pkg.sv ====
// Summary of operation
// [RQ1] Write trigger starts write, self-clears when done
// [RQ2] Write trigger ignored unless permit already high
// [RQ3] Control bit 1 is read permit
// [RQ4] Control bit 0 read trigger, self-clears
// [RQ5] No read while read permit low
// [RQ6] Software never sets all bits or both triggers
// [RQ7] Data register holds fetched byte until next operation
// [RQ8] Software loads permit, address, data before write
// [RQ9] Write timed by asynchronous internal timer
// [RQ10] Reset clears write permit
// [RQ11] Write end sets memory and shared flags
// [RQ12] Vector only with all three enables set
// [RQ13] Service clears shared flag; software clears memory flag
// [RQ14] Software sets trigger right after permit
// [RQ15] Software masks global interrupt around write start
// [RQ16] Software avoids sleep during pending operation
// [RQ17] Control in bank one; reset selects bank zero
// [RQ18] 64-byte array, 6-bit address, 8-bit data
// [RQ19] Control bit 3 is write permit
// [RQ20] Counters set read latency and write duration
// [RQ21] Control bits 7 to 4 read zero

package nv_pkg;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int NV_DEPTH = 64;
    localparam int NV_ADDR_W = 6;
    localparam int NV_DATA_W = 8;

    // ------------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] SFR_INDIRECT = 8'h02;
    localparam logic [7:0] SFR_BANK_LOW = 8'h03;
    localparam logic [7:0] SFR_BANK_HIGH = 8'h04;
    localparam logic [7:0] SFR_NV_ADDR = 8'h1a;
    localparam logic [7:0] SFR_NV_DATA = 8'h1b;
    localparam logic [7:0] SFR_IRQ_CTRL = 8'h1c;

    // Control register location behind the indirect port
    localparam logic [7:0] CTRL_OFFSET = 8'h40;
    localparam logic [7:0] CTRL_BANK = 8'h01;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_RD_TRIG = 0;
    localparam int CTRL_RD_PERMIT = 1;
    localparam int CTRL_WR_TRIG = 2;
    localparam int CTRL_WR_PERMIT = 3;

    // ------------------------------------------------------------------
    // Interrupt control register fields
    // ------------------------------------------------------------------
    localparam int IRQ_NV_EN = 0;
    localparam int IRQ_MF_EN = 1;
    localparam int IRQ_GLOBAL_EN = 2;
    localparam int IRQ_NV_FLAG = 4;
    localparam int IRQ_MF_FLAG = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_ADDR = 6'h00;

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam logic [3:0] READ_CYCLES = 4'h4;
    localparam logic [7:0] WRITE_TICKS = 8'h10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } nv_state_t;

endpackage

// ==== rtl/nv_write_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

module nv_write_timer
    import nv_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Asynchronous timer source
    input wire logic i_timer_clk,
    // Control
    input wire logic i_start,
    output logic o_done
);

    // ------------------------------------------------------------------
    // Timer input synchroniser
    // ------------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic level_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [7:0] ticks_r;
    logic [7:0] ticks_nxt;
    logic tick;

    always_comb begin
        level_nxt = level_r;
        if (sync2_r == sync3_r) begin
            level_nxt = sync3_r;
        end
    end

    assign tick = level_nxt && !level_r;

    // ------------------------------------------------------------------
    // Tick counter
    // ------------------------------------------------------------------
    always_comb begin
        busy_nxt = busy_r;
        ticks_nxt = ticks_r;
        o_done = 1'b0;
        if (i_start) begin
            busy_nxt = 1'b1;
            ticks_nxt = 8'h00;
        end else if (busy_r && tick) begin
            if (ticks_r == WRITE_TICKS - 8'h01) begin // RQ9
                busy_nxt = 1'b0;
                o_done = 1'b1;
            end
            ticks_nxt = ticks_r + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            level_r <= 1'b0;
            busy_r <= 1'b0;
            ticks_r <= 8'h00;
        end else begin
            sync1_r <= i_timer_clk;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= level_nxt;
            busy_r <= busy_nxt;
            ticks_r <= ticks_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/eeprom_data_access_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module eeprom_data_access_ctrl
    import nv_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Special function register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_we,
    input wire logic i_sfr_re,
    output logic [7:0] o_sfr_rdata,
    // Interrupt
    input wire logic i_irq_ack,
    output logic o_irq_req,
    // Asynchronous write timer source
    input wire logic i_nv_timer_clk,
    // Status
    output logic o_nv_busy
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    nv_state_t state_r;
    nv_state_t state_nxt;

    logic [NV_ADDR_W-1:0] nv_address_reg_r;
    logic [NV_ADDR_W-1:0] nv_address_reg_nxt;
    logic [NV_DATA_W-1:0] nv_data_reg_r;
    logic [NV_DATA_W-1:0] nv_data_reg_nxt;
    logic [7:0] bank_pointer_low_r;
    logic [7:0] bank_pointer_low_nxt;
    logic [7:0] bank_pointer_high_r;
    logic [7:0] bank_pointer_high_nxt;

    logic write_permit_r;
    logic write_permit_nxt;
    logic read_permit_r;
    logic read_permit_nxt;
    logic wr_trig_r;
    logic wr_trig_nxt;
    logic rd_trig_r;
    logic rd_trig_nxt;

    logic [NV_ADDR_W-1:0] op_addr_r;
    logic [NV_ADDR_W-1:0] op_addr_nxt;
    logic [NV_DATA_W-1:0] op_data_r;
    logic [NV_DATA_W-1:0] op_data_nxt;
    logic [3:0] rd_cnt_r;
    logic [3:0] rd_cnt_nxt;

    logic nv_irq_enable_r;
    logic nv_irq_enable_nxt;
    logic mf_irq_enable_r;
    logic mf_irq_enable_nxt;
    logic global_irq_enable_r;
    logic global_irq_enable_nxt;
    logic nv_irq_flag_r;
    logic nv_irq_flag_nxt;
    logic mf_irq_flag_r;
    logic mf_irq_flag_nxt;

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic [NV_DATA_W-1:0] mem_r [NV_DEPTH];
    logic mem_we;

    logic ctrl_sel;
    logic ctrl_we;
    logic addr_we;
    logic data_we;
    logic bank_low_we;
    logic bank_high_we;
    logic irq_we;
    logic start_write;
    logic start_read;
    logic read_done;
    logic write_done;

    // ------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------
    function automatic logic [7:0] ctrl_image(
        input logic wp,
        input logic wt,
        input logic rp,
        input logic rt
    );
        logic [7:0] v;
        v = 8'h00; // RQ21
        v[CTRL_WR_PERMIT] = wp;
        v[CTRL_WR_TRIG] = wt;
        v[CTRL_RD_PERMIT] = rp;
        v[CTRL_RD_TRIG] = rt;
        return v;
    endfunction

    function automatic logic sfr_hit(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction

    // ------------------------------------------------------------------
    // Write timer
    // ------------------------------------------------------------------
    nv_write_timer i_nv_write_timer (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_timer_clk(i_nv_timer_clk),
        .i_start(start_write),
        .o_done(write_done)
    );

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    assign ctrl_sel = (bank_pointer_high_r == CTRL_BANK) &&
                      (bank_pointer_low_r == CTRL_OFFSET); // RQ17
    assign ctrl_we = i_sfr_we && sfr_hit(i_sfr_addr, SFR_INDIRECT) &&
                     ctrl_sel;
    assign addr_we = i_sfr_we && sfr_hit(i_sfr_addr, SFR_NV_ADDR);
    assign data_we = i_sfr_we && sfr_hit(i_sfr_addr, SFR_NV_DATA);
    assign bank_low_we = i_sfr_we && sfr_hit(i_sfr_addr, SFR_BANK_LOW);
    assign bank_high_we = i_sfr_we && sfr_hit(i_sfr_addr, SFR_BANK_HIGH);
    assign irq_we = i_sfr_we && sfr_hit(i_sfr_addr, SFR_IRQ_CTRL);

    // Trigger accepted only if its permit was already set
    assign start_write = ctrl_we && i_sfr_wdata[CTRL_WR_TRIG] &&
                         write_permit_r && (state_r == ST_IDLE); // RQ2
    assign start_read = ctrl_we && i_sfr_wdata[CTRL_RD_TRIG] &&
                        read_permit_r && (state_r == ST_IDLE) &&
                        !start_write; // RQ5
    assign read_done = (state_r == ST_READ) &&
                       (rd_cnt_r == READ_CYCLES - 4'h1); // RQ20

    // ------------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        rd_cnt_nxt = rd_cnt_r;
        op_addr_nxt = op_addr_r;
        op_data_nxt = op_data_r;
        mem_we = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                rd_cnt_nxt = 4'h0;
                if (start_write) begin
                    state_nxt = ST_WRITE; // RQ1
                    op_addr_nxt = nv_address_reg_r;
                    op_data_nxt = nv_data_reg_r;
                end else if (start_read) begin
                    state_nxt = ST_READ; // RQ4
                    op_addr_nxt = nv_address_reg_r;
                end
            end
            ST_READ: begin
                rd_cnt_nxt = rd_cnt_r + 4'h1;
                if (read_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (write_done) begin
                    state_nxt = ST_IDLE;
                    mem_we = 1'b1; // RQ18
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_comb begin
        write_permit_nxt = write_permit_r;
        read_permit_nxt = read_permit_r;
        wr_trig_nxt = wr_trig_r;
        rd_trig_nxt = rd_trig_r;
        if (ctrl_we) begin
            write_permit_nxt = i_sfr_wdata[CTRL_WR_PERMIT]; // RQ19
            read_permit_nxt = i_sfr_wdata[CTRL_RD_PERMIT]; // RQ3
        end
        if (start_write) begin
            wr_trig_nxt = 1'b1;
        end else if (write_done) begin
            wr_trig_nxt = 1'b0; // RQ1
        end
        if (start_read) begin
            rd_trig_nxt = 1'b1;
        end else if (read_done) begin
            rd_trig_nxt = 1'b0; // RQ4
        end
    end

    // ------------------------------------------------------------------
    // Direct registers
    // ------------------------------------------------------------------
    always_comb begin
        nv_address_reg_nxt = nv_address_reg_r;
        nv_data_reg_nxt = nv_data_reg_r;
        bank_pointer_low_nxt = bank_pointer_low_r;
        bank_pointer_high_nxt = bank_pointer_high_r;
        if (addr_we) begin
            nv_address_reg_nxt = i_sfr_wdata[NV_ADDR_W-1:0];
        end
        if (read_done) begin
            nv_data_reg_nxt = mem_r[op_addr_r]; // RQ7
        end else if (data_we) begin
            nv_data_reg_nxt = i_sfr_wdata;
        end
        if (bank_low_we) begin
            bank_pointer_low_nxt = i_sfr_wdata;
        end
        if (bank_high_we) begin
            bank_pointer_high_nxt = i_sfr_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags and enables
    // ------------------------------------------------------------------
    always_comb begin
        nv_irq_enable_nxt = nv_irq_enable_r;
        mf_irq_enable_nxt = mf_irq_enable_r;
        global_irq_enable_nxt = global_irq_enable_r;
        nv_irq_flag_nxt = nv_irq_flag_r;
        mf_irq_flag_nxt = mf_irq_flag_r;
        if (irq_we) begin
            nv_irq_enable_nxt = i_sfr_wdata[IRQ_NV_EN];
            mf_irq_enable_nxt = i_sfr_wdata[IRQ_MF_EN];
            global_irq_enable_nxt = i_sfr_wdata[IRQ_GLOBAL_EN];
            nv_irq_flag_nxt = i_sfr_wdata[IRQ_NV_FLAG];
            mf_irq_flag_nxt = i_sfr_wdata[IRQ_MF_FLAG];
        end
        if (i_irq_ack) begin
            mf_irq_flag_nxt = 1'b0; // RQ13
        end
        // A write end in the clearing cycle still sets both flags
        if (write_done) begin
            nv_irq_flag_nxt = 1'b1; // RQ11
            mf_irq_flag_nxt = 1'b1; // RQ11
        end
    end

    assign o_irq_req = mf_irq_flag_r && nv_irq_enable_r &&
                       mf_irq_enable_r && global_irq_enable_r; // RQ12
    assign o_nv_busy = (state_r != ST_IDLE);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (i_sfr_re) begin
            rdata_nxt = 8'h00;
            if (sfr_hit(i_sfr_addr, SFR_NV_ADDR)) begin
                rdata_nxt = {2'b00, nv_address_reg_r};
            end else if (sfr_hit(i_sfr_addr, SFR_NV_DATA)) begin
                rdata_nxt = nv_data_reg_r;
            end else if (sfr_hit(i_sfr_addr, SFR_BANK_LOW)) begin
                rdata_nxt = bank_pointer_low_r;
            end else if (sfr_hit(i_sfr_addr, SFR_BANK_HIGH)) begin
                rdata_nxt = bank_pointer_high_r;
            end else if (sfr_hit(i_sfr_addr, SFR_IRQ_CTRL)) begin
                rdata_nxt[IRQ_NV_EN] = nv_irq_enable_r;
                rdata_nxt[IRQ_MF_EN] = mf_irq_enable_r;
                rdata_nxt[IRQ_GLOBAL_EN] = global_irq_enable_r;
                rdata_nxt[IRQ_NV_FLAG] = nv_irq_flag_r;
                rdata_nxt[IRQ_MF_FLAG] = mf_irq_flag_r;
            end else if (sfr_hit(i_sfr_addr, SFR_INDIRECT) && ctrl_sel) begin
                rdata_nxt = ctrl_image(write_permit_r, wr_trig_r,
                                       read_permit_r, rd_trig_r); // RQ17
            end
        end
    end

    assign o_sfr_rdata = rdata_r;

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            rd_cnt_r <= 4'h0;
            op_addr_r <= RST_ADDR;
            op_data_r <= RST_BYTE;
            nv_address_reg_r <= RST_ADDR;
            nv_data_reg_r <= RST_BYTE;
            bank_pointer_low_r <= RST_BYTE;
            bank_pointer_high_r <= RST_BYTE; // RQ17
            write_permit_r <= 1'b0; // RQ10
            read_permit_r <= 1'b0;
            wr_trig_r <= 1'b0;
            rd_trig_r <= 1'b0;
            nv_irq_enable_r <= 1'b0;
            mf_irq_enable_r <= 1'b0;
            global_irq_enable_r <= 1'b0;
            nv_irq_flag_r <= 1'b0;
            mf_irq_flag_r <= 1'b0;
            rdata_r <= RST_BYTE;
        end else begin
            state_r <= state_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            op_addr_r <= op_addr_nxt;
            op_data_r <= op_data_nxt;
            nv_address_reg_r <= nv_address_reg_nxt;
            nv_data_reg_r <= nv_data_reg_nxt;
            bank_pointer_low_r <= bank_pointer_low_nxt;
            bank_pointer_high_r <= bank_pointer_high_nxt;
            write_permit_r <= write_permit_nxt;
            read_permit_r <= read_permit_nxt;
            wr_trig_r <= wr_trig_nxt;
            rd_trig_r <= rd_trig_nxt;
            nv_irq_enable_r <= nv_irq_enable_nxt;
            mf_irq_enable_r <= mf_irq_enable_nxt;
            global_irq_enable_r <= global_irq_enable_nxt;
            nv_irq_flag_r <= nv_irq_flag_nxt;
            mf_irq_flag_r <= mf_irq_flag_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Non-volatile array
    // ------------------------------------------------------------------
    // Contents survive reset, so the array has no reset branch
    always_ff @(posedge i_core_clk) begin
        if (mem_we) begin
            mem_r[op_addr_r] <= op_data_r; // RQ1
        end
    end

endmodule

`default_nettype wire

// ==== verification/eeprom_data_access_ctrl_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

module eeprom_data_access_ctrl_checker
    import nv_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_we,
    input wire logic i_sfr_re,
    input wire logic [7:0] o_sfr_rdata,
    // Interrupt and status
    input wire logic i_irq_ack,
    input wire logic o_irq_req,
    input wire logic i_nv_timer_clk,
    input wire logic o_nv_busy
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic mapped;
    assign mapped = (i_sfr_addr == SFR_INDIRECT) ||
        (i_sfr_addr == SFR_BANK_LOW) || (i_sfr_addr == SFR_BANK_HIGH) ||
        (i_sfr_addr == SFR_NV_ADDR) || (i_sfr_addr == SFR_NV_DATA) ||
        (i_sfr_addr == SFR_IRQ_CTRL);

    sequence op_start;
        $rose(o_nv_busy);
    endsequence

    sequence op_done;
        ##[1:400] !o_nv_busy;
    endsequence

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_rdata_holds: assert property (!i_sfr_re |=> $stable(o_sfr_rdata))
        else $error("read data moved without a read strobe");
    a_unmapped_zero: assert property (i_sfr_re && !mapped |=>
        o_sfr_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_busy_cause: assert property (op_start |-> $past(i_sfr_we) &&
        $past(i_sfr_addr) == SFR_INDIRECT)
        else $error("operation started without a control write");
    a_read_min_len: assert property (op_start |-> o_nv_busy [*3])
        else $error("operation ended too soon");
    a_op_ends: assert property (op_start |-> op_done)
        else $error("operation never finished");
    a_ack_clears: assert property (i_irq_ack && o_irq_req &&
        !o_nv_busy && !i_sfr_we |=> !o_irq_req)
        else $error("service did not drop the request");
    a_irq_cause: assert property ($rose(o_irq_req) |->
        $past(i_sfr_we) || $past(o_nv_busy))
        else $error("request rose with no cause");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_rst |-> !o_nv_busy && !o_irq_req && o_sfr_rdata == 8'h00)
        else $error("outputs active in reset");
    c_op: cover property (op_start ##1 op_done);
endmodule

bind eeprom_data_access_ctrl eeprom_data_access_ctrl_checker i_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_we(i_sfr_we), .i_sfr_re(i_sfr_re),
    .o_sfr_rdata(o_sfr_rdata), .i_irq_ack(i_irq_ack),
    .o_irq_req(o_irq_req), .i_nv_timer_clk(i_nv_timer_clk),
    .o_nv_busy(o_nv_busy));

`default_nettype wire

// ==== verification/tb_eeprom_data_access_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_eeprom_data_access_ctrl
    import nv_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_sfr_we = 1'b0;
    logic i_sfr_re = 1'b0;
    logic i_irq_ack = 1'b0;
    logic i_nv_timer_clk = 1'b0;
    logic [7:0] o_sfr_rdata;
    logic o_irq_req;
    logic o_nv_busy;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    eeprom_data_access_ctrl i_eeprom_data_access_ctrl (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
        .i_sfr_wdata(i_sfr_wdata), .i_sfr_we(i_sfr_we),
        .i_sfr_re(i_sfr_re), .o_sfr_rdata(o_sfr_rdata),
        .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req),
        .i_nv_timer_clk(i_nv_timer_clk), .o_nv_busy(o_nv_busy));

    // ------------------------------------------------------------------
    // Clocks and timeout
    // ------------------------------------------------------------------
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    // Write timer source, unrelated in phase to the core clock
    initial begin
        #7;
        forever #65 i_nv_timer_clk = ~i_nv_timer_clk;
    end
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_we = 1'b1;
        @(negedge i_core_clk);
        i_sfr_we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        i_sfr_addr = a;
        i_sfr_re = 1'b1;
        @(negedge i_core_clk);
        i_sfr_re = 1'b0;
        d = o_sfr_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (o_nv_busy !== 1'b0 && n < 400) begin
            @(negedge i_core_clk);
            n = n + 1;
        end
        chk({7'h00, o_nv_busy}, 8'h00);
    endtask

    task automatic do_reset();
        @(negedge i_core_clk);
        i_rst = 1'b1;
        repeat (3) @(negedge i_core_clk);
        i_rst = 1'b0;
    endtask

    task automatic bank_on();
        wr(SFR_BANK_LOW, CTRL_OFFSET);
        wr(SFR_BANK_HIGH, CTRL_BANK);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(SFR_BANK_HIGH, 8'h00);
        rd_chk(SFR_NV_ADDR, RST_BYTE);
        rd_chk(SFR_NV_DATA, RST_BYTE);
        bank_on();
        rd_chk(SFR_INDIRECT, 8'h00);
        chk({6'h00, o_irq_req, o_nv_busy}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_protect();
        wr(SFR_BANK_HIGH, 8'h00);
        wr(SFR_INDIRECT, 8'h08);
        bank_on();
        rd_chk(SFR_INDIRECT, 8'h00);
        wr(SFR_INDIRECT, 8'h04);
        chk({7'h00, o_nv_busy}, 8'h00);
        wr(SFR_INDIRECT, 8'h01);
        chk({7'h00, o_nv_busy}, 8'h00);
        rd_chk(SFR_INDIRECT, 8'h00);
        wr(SFR_INDIRECT, 8'hfa);
        rd_chk(SFR_INDIRECT, 8'h0a);
        rd_chk(8'h7f, 8'h00);
        $display("test protect done");
    endtask

    task automatic t_write(input logic [7:0] a, input logic [7:0] d);
        wr(SFR_IRQ_CTRL, 8'h00);
        wr(SFR_NV_ADDR, a);
        wr(SFR_NV_DATA, d);
        wr(SFR_INDIRECT, 8'h08);
        wr(SFR_INDIRECT, 8'h0c);
        chk({7'h00, o_nv_busy}, 8'h01);
        rd_chk(SFR_INDIRECT, 8'h0c);
        wait_idle();
        rd_chk(SFR_INDIRECT, 8'h08);
        rd_chk(SFR_IRQ_CTRL, 8'h30);
        $display("test write done");
    endtask

    task automatic t_read(input logic [7:0] a, input logic [7:0] d);
        wr(SFR_NV_DATA, 8'h00);
        wr(SFR_NV_ADDR, a);
        wr(SFR_INDIRECT, 8'h02);
        wr(SFR_INDIRECT, 8'h03);
        chk({7'h00, o_nv_busy}, 8'h01);
        wait_idle();
        rd_chk(SFR_INDIRECT, 8'h02);
        rd_chk(SFR_NV_DATA, d);
        repeat (20) @(negedge i_core_clk);
        rd_chk(SFR_NV_DATA, d);
        $display("test read done");
    endtask

    task automatic t_irq();
        wr(SFR_IRQ_CTRL, 8'h33);
        chk({7'h00, o_irq_req}, 8'h00);
        wr(SFR_IRQ_CTRL, 8'h36);
        chk({7'h00, o_irq_req}, 8'h00);
        wr(SFR_IRQ_CTRL, 8'h37);
        chk({7'h00, o_irq_req}, 8'h01);
        @(negedge i_core_clk);
        i_irq_ack = 1'b1;
        @(negedge i_core_clk);
        i_irq_ack = 1'b0;
        chk({7'h00, o_irq_req}, 8'h00);
        rd_chk(SFR_IRQ_CTRL, 8'h17);
        wr(SFR_IRQ_CTRL, 8'h07);
        rd_chk(SFR_IRQ_CTRL, 8'h07);
        $display("test irq done");
    endtask

    initial begin
        // Raised after time zero so the asynchronous reset sees an edge
        #1;
        i_rst = 1'b1;
        repeat (3) @(negedge i_core_clk);
        i_rst = 1'b0;
        t_reset();
        t_protect();
        t_write(8'h00, 8'ha5);
        t_write(8'h3f, 8'h5a);
        t_read(8'h00, 8'ha5);
        t_read(8'h3f, 8'h5a);
        t_write(8'h3f, 8'hc3);
        t_irq();
        wr(SFR_INDIRECT, 8'h08);
        do_reset();
        t_reset();
        end_sim();
    end
endmodule

`default_nettype wire
